// ==== include/pmw_map.svh ====
`ifndef PMW_MAP_SVH
`define PMW_MAP_SVH
`define ADDR_CTRL       4'h0
`define ADDR_AUX        4'h4
`define ADDR_WAKE       4'h8
`define ADDR_STATUS     4'hC
`define AUX_TMO_LSB     0
`define AUX_FASTWAKE    5
`define AUX_RST         8'h00
`define CTRL_CLEAR_BIT  0
`define CTRL_SAVE_BIT   1
`define CTRL_DOWN_BIT   2
`define WAKE_CMPEN_BIT  7
`define WAKE_CMPWK_BIT  6
`define WAKE_RST        8'h00
`define TMO_8K          20'h02000
`define TMO_16K         20'h04000
`define TMO_64K         20'h10000
`define TMO_256K        20'h40000
`define WAKE_NORMAL     12'hBB8
`define WAKE_FAST       12'h02D
`define NPINS           14
`define NTIMERS         6
`define RESET_PULSE     4'h8
`endif

// ==== include/pmw_pkg.sv ====
package pmw_pkg;
  typedef enum logic [1:0] {
    ST_ON,
    ST_SAVE,
    ST_DOWN,
    ST_WAKE
  } mode_type;
endpackage : pmw_pkg

// ==== design/lsclk_sync.sv ====
`timescale 1ns/1ns
// Two-flop synchroniser with a registered edge detector behind the second stage.
module lsclk_sync (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic d_i,
  output logic      level_o,
  output logic      rise_o,
  output logic      edge_o
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic s1_nxt;
  logic s2_nxt;
  logic s3_nxt;

  always_comb begin
    s1_nxt = d_i;
    s2_nxt = s1_r;
    s3_nxt = s2_r;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      s3_r <= s3_nxt;
    end
  end

  assign level_o = s2_r;
  assign rise_o  = s2_r & ~s3_r;
  assign edge_o  = s2_r ^ s3_r;
endmodule : lsclk_sync

// ==== design/power_mode_wakeup_watchdog.sv ====
// Decided for this implementation: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ns
`include "pmw_map.svh"
// How it works
// - Watchdog counts low-speed RC edges; cleared by power-on reset or clear instruction.
// - Aux bits 1:0 pick timeout 8k, 16k, 64k or 256k low-speed clocks.
// - Reaching the timeout asserts chip reset so execution restarts.
// - Power-save gates only the system clock, oscillators keep running.
// - In power-save timers on system clock or disabled oscillator stop.
// - Low-speed RC stays on in power-save; resume runs on it.
// - Program memory is off in both sleeps, re-enabled before fetch resumes.
// - Power-save pin wake needs input mode and digital-input-enable set.
// - Power-save timer wake when a non-system-clocked timer reaches its value.
// - Comparator wake needs comparator enable and wake enable bits both set.
// - Power-down stops every oscillator; registers and memory are kept.
// - Power-down wakes only on an enabled pin toggle.
// - Timer wake honoured in power-save only.
// - Wake-up continues at the next instruction, not a restart.
// - Aux bit 5 picks about 3000 or 45 low-speed clocks of wake delay.
// - Fast boot-up option forces fast wake regardless of aux bit 5.
module power_mode_wakeup_watchdog #(
  parameter bit FAST_BOOT = 1'b0
) (
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     cyc_i,
  input  wire logic                     stb_i,
  input  wire logic                     we_i,
  input  wire logic [3:0]               adr_i,
  input  wire logic [3:0]               sel_i,
  input  wire logic [31:0]              dat_i,
  output logic      [31:0]              dat_o,
  output logic                          ack_o,
  input  wire logic                     lsclk_i,
  input  wire logic                     hsrc_en_i,
  input  wire logic                     xtal_en_i,
  input  wire logic [`NPINS-1:0]        pin_i,
  input  wire logic [`NPINS-1:0]        pin_direction_ctrl_i,
  input  wire logic [`NPINS-1:0]        pin_dier_i,
  input  wire logic [`NTIMERS-1:0]      timer_on_system_clock_i,
  input  wire logic [`NTIMERS-1:0]      timer_osc_off_i,
  input  wire logic [`NTIMERS-1:0]      timer_match_i,
  input  wire logic                     cmp_event_i,
  output logic                          system_clock_en_o,
  output logic                          high_speed_rc_osc_en_o,
  output logic                          low_speed_rc_osc_en_o,
  output logic                          crystal_oscillator_en_o,
  output logic                          program_memory_en_o,
  output logic [`NTIMERS-1:0]           timer_run_o,
  output logic                          resume_o,
  output logic                          chip_reset_o
);
  pmw_pkg::mode_type mode_r;
  pmw_pkg::mode_type mode_nxt;
  logic [7:0]               aux_r;
  logic [7:0]               aux_nxt;
  logic [7:0]               wake_r;
  logic [7:0]               wake_nxt;
  logic [19:0]              wdog_r;
  logic [19:0]              wdog_nxt;
  logic [11:0]              wcnt_r;
  logic [11:0]              wcnt_nxt;
  logic [3:0]               rpulse_r;
  logic [3:0]               rpulse_nxt;
  logic                     ack_r;
  logic                     ack_nxt;
  logic [31:0]              dat_r;
  logic [31:0]              dat_nxt;
  logic                     ls_rise;
  logic [`NPINS-1:0]        pin_lvl_r;
  logic [`NPINS-1:0]        pin_mid_r;
  logic [`NPINS-1:0]        pin_old_r;
  logic                     cmp_lvl;
  logic                     wr;
  logic                     pin_wake;
  logic                     tmr_wake;
  logic                     cmp_wake;
  logic                     clear_cmd;
  logic [`NTIMERS-1:0]      tmr_alive;

  logic [`NPINS-1:0]        pin_tgl;
  logic [`NPINS-1:0]        pin_mid_nxt;
  logic [`NPINS-1:0]        pin_lvl_nxt;
  logic [`NPINS-1:0]        pin_old_nxt;

  // Each synchronised rising edge of the low-speed clock is one tick.
  lsclk_sync u_ls (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .d_i     (lsclk_i),
    .level_o (),
    .rise_o  (ls_rise),
    .edge_o  ()
  );

  // Only a rising comparator edge counts, so a level held high wakes once.
  lsclk_sync u_cmp (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .d_i     (cmp_event_i),
    .level_o (),
    .rise_o  (cmp_lvl),
    .edge_o  ()
  );

  // Pins are asynchronous, so two flops come before the toggle compare.
  // Reset clears every stage, so a pin resting low shows no false toggle.
  always_comb begin
    pin_mid_nxt = pin_i;
    pin_lvl_nxt = pin_mid_r;
    pin_old_nxt = pin_lvl_r;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_mid_r <= '0;
      pin_lvl_r <= '0;
      pin_old_r <= '0;
    end else begin
      pin_mid_r <= pin_mid_nxt;
      pin_lvl_r <= pin_lvl_nxt;
      pin_old_r <= pin_old_nxt;
    end
  end

  function automatic logic [19:0] tmo_sel(input logic [1:0] s);
    unique case (s)
      2'b00: tmo_sel = `TMO_8K;
      2'b01: tmo_sel = `TMO_16K;
      2'b10: tmo_sel = `TMO_64K;
      2'b11: tmo_sel = `TMO_256K;
    endcase
  endfunction : tmo_sel

  // Write strobe aimed at one register address.
  function automatic logic wr_hit(input logic w, input logic [3:0] a, input logic [3:0] t);
    wr_hit = w & (a == t);
  endfunction : wr_hit

  // A write lands at the edge where the master sees ack, so it is taken exactly once.
  assign wr        = cyc_i & stb_i & we_i & ack_r & sel_i[0];
  assign clear_cmd = wr_hit(wr, adr_i, `ADDR_CTRL) & dat_i[`CTRL_CLEAR_BIT];
  assign pin_tgl   = pin_lvl_r ^ pin_old_r;
  assign tmr_alive = ~timer_on_system_clock_i & ~timer_osc_off_i;

  // pin wake gating; pin_direction_ctrl bit 1 means input here.
  // pin toggle only source in power-down.
  assign pin_wake = |(pin_tgl & pin_dier_i &
                     ((mode_r == pmw_pkg::ST_SAVE) ? pin_direction_ctrl_i : {`NPINS{1'b1}}));
  assign tmr_wake = (mode_r == pmw_pkg::ST_SAVE) & |(timer_match_i & tmr_alive);
  assign cmp_wake = (mode_r == pmw_pkg::ST_SAVE) & cmp_lvl &
                    wake_r[`WAKE_CMPEN_BIT] & wake_r[`WAKE_CMPWK_BIT];

  // Read data is latched with ack and stands only while ack stands.
  always_comb begin
    ack_nxt = cyc_i & stb_i & ~ack_r;
    dat_nxt = 32'h0000_0000;
    if (cyc_i & stb_i & ~we_i & ~ack_r) begin
      unique case (adr_i)
        `ADDR_AUX:    dat_nxt = {24'h00_0000, aux_r};
        `ADDR_WAKE:   dat_nxt = {24'h00_0000, wake_r};
        `ADDR_STATUS: dat_nxt = {12'h000, wdog_r};
        default:      dat_nxt = {30'h0, mode_r};
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
    end
  end

  // Only byte lane zero carries aux and wake bits; their upper lanes read as zero, but status returns all 20 watchdog bits.
  always_comb begin
    aux_nxt  = aux_r;
    wake_nxt = wake_r;
    if (wr_hit(wr, adr_i, `ADDR_AUX)) begin
      aux_nxt = dat_i[7:0];
    end
    if (wr_hit(wr, adr_i, `ADDR_WAKE)) begin
      wake_nxt = dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      aux_r  <= `AUX_RST;
      wake_r <= `WAKE_RST;
    end else begin
      aux_r  <= aux_nxt;
      wake_r <= wake_nxt;
    end
  end

  always_comb begin
    mode_nxt = mode_r;
    wcnt_nxt = wcnt_r;
    unique case (mode_r)
      pmw_pkg::ST_ON: begin
        // Down outranks save when software sets both bits.
        if (wr_hit(wr, adr_i, `ADDR_CTRL) & dat_i[`CTRL_DOWN_BIT]) begin
          mode_nxt = pmw_pkg::ST_DOWN;
        end else if (wr_hit(wr, adr_i, `ADDR_CTRL) & dat_i[`CTRL_SAVE_BIT]) begin
          mode_nxt = pmw_pkg::ST_SAVE;
        end
      end
      pmw_pkg::ST_SAVE, pmw_pkg::ST_DOWN: begin
        if (pin_wake | tmr_wake | cmp_wake) begin
          mode_nxt = pmw_pkg::ST_WAKE;
          wcnt_nxt = (FAST_BOOT | aux_r[`AUX_FASTWAKE]) ? `WAKE_FAST : `WAKE_NORMAL;
        end
      end
      pmw_pkg::ST_WAKE: begin
        // resume, no restart.
        // The delay runs on low-speed ticks, so it drifts with that oscillator.
        if (ls_rise) begin
          wcnt_nxt = wcnt_r - 12'h001;
          if (wcnt_r == 12'h001) begin
            mode_nxt = pmw_pkg::ST_ON;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_r <= pmw_pkg::ST_ON;
      wcnt_r <= 12'h000;
    end else begin
      mode_r <= mode_nxt;
      wcnt_r <= wcnt_nxt;
    end
  end

  always_comb begin
    wdog_nxt   = wdog_r;
    rpulse_nxt = (rpulse_r != 4'h0) ? rpulse_r - 4'h1 : 4'h0;
    if (clear_cmd) begin
      wdog_nxt = 20'h00000;
    end else if (ls_rise & (mode_r != pmw_pkg::ST_DOWN)) begin
      wdog_nxt = wdog_r + 20'h00001;
      if (wdog_nxt >= tmo_sel(aux_r[1:0])) begin
        wdog_nxt   = 20'h00000;
        rpulse_nxt = `RESET_PULSE;
      end
    end
  end

  // The pulse leaves through chip_reset_o; the system returns it on rst_i to restart everything.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wdog_r   <= 20'h00000;
      rpulse_r <= 4'h0;
    end else begin
      wdog_r   <= wdog_nxt;
      rpulse_r <= rpulse_nxt;
    end
  end

  assign ack_o = ack_r;
  assign dat_o = dat_r;
  assign system_clock_en_o       = (mode_r == pmw_pkg::ST_ON);
  assign high_speed_rc_osc_en_o  = hsrc_en_i & (mode_r != pmw_pkg::ST_DOWN);
  assign low_speed_rc_osc_en_o   = (mode_r != pmw_pkg::ST_DOWN);
  assign crystal_oscillator_en_o = xtal_en_i & (mode_r != pmw_pkg::ST_DOWN);
  assign program_memory_en_o     = (mode_r == pmw_pkg::ST_ON);

  always_comb begin
    unique case (mode_r)
      pmw_pkg::ST_ON:                     timer_run_o = {`NTIMERS{1'b1}};
      pmw_pkg::ST_DOWN:                   timer_run_o = {`NTIMERS{1'b0}};
      pmw_pkg::ST_SAVE, pmw_pkg::ST_WAKE: timer_run_o = tmr_alive;
    endcase
  end

  assign resume_o     = (mode_r == pmw_pkg::ST_WAKE) & (mode_nxt == pmw_pkg::ST_ON);
  assign chip_reset_o = (rpulse_r != 4'h0);
endmodule : power_mode_wakeup_watchdog

// ==== sim/low_speed_rc_osc_model.sv ====
`timescale 1ns/1ns
module low_speed_rc_osc_model (
  input  wire logic clk_i,
  input  wire logic en_i,
  output logic      lsclk_o = 1'b0
);
  logic [1:0] div_r = 2'h0;
  // The clock stands still while disabled.
  always @(posedge clk_i) begin
    div_r <= div_r + {1'b0, en_i};
    lsclk_o <= en_i & div_r[1];
  end
endmodule : low_speed_rc_osc_model

// ==== sim/power_mode_wakeup_watchdog_asserts.sv ====
`timescale 1ns/1ns
module pmw_asserts (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       hsrc_en_i,
  input wire logic [5:0] timer_on_system_clock_i,
  input wire logic [5:0] timer_run_o,
  input wire logic       system_clock_en_o,
  input wire logic       high_speed_rc_osc_en_o,
  input wire logic       low_speed_rc_osc_en_o,
  input wire logic       program_memory_en_o,
  input wire logic       resume_o,
  input wire logic       chip_reset_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence rst_pulse_s;
    chip_reset_o [*8] ##1 !chip_reset_o;
  endsequence
  AST_RST_LEN: assert property ($rose(chip_reset_o) |-> rst_pulse_s) else $error("reset pulse");
  AST_HOLD: assert property (!low_speed_rc_osc_en_o |-> !$rose(chip_reset_o)) else $error("reset asleep");
  AST_DOWN_OFF: assert property (!low_speed_rc_osc_en_o |-> !high_speed_rc_osc_en_o && !system_clock_en_o)
    else $error("osc on");
  AST_SAVE_OSC: assert property ($fell(system_clock_en_o) && low_speed_rc_osc_en_o |->
    high_speed_rc_osc_en_o == hsrc_en_i) else $error("osc stopped");
  AST_PMEM: assert property ($fell(system_clock_en_o) |-> !program_memory_en_o) else $error("memory on");
  AST_TMR: assert property (!system_clock_en_o |-> (timer_run_o & timer_on_system_clock_i) == 6'h00)
    else $error("timer runs");
  AST_RESUME: assert property (resume_o |-> ##[0:1] (system_clock_en_o && program_memory_en_o))
    else $error("resume");
  AST_RESUME_ONE: assert property (resume_o |=> !resume_o) else $error("resume long");
endmodule : pmw_asserts
bind power_mode_wakeup_watchdog pmw_asserts u_asserts (.clk_i, .rst_i, .hsrc_en_i, .timer_on_system_clock_i,
  .timer_run_o, .system_clock_en_o, .high_speed_rc_osc_en_o, .low_speed_rc_osc_en_o, .program_memory_en_o,
  .resume_o, .chip_reset_o);

// ==== sim/power_mode_wakeup_watchdog_test.sv ====
`timescale 1ns/1ns
`include "pmw_map.svh"
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fails++; $display("Error %0t %h %h", $time, a, e); end end
module power_mode_wakeup_watchdog_test;
  logic        clk = 1'b0, rst = 1'b1, req = 1'b0, we = 1'b0, xt = 1'b1, cmp = 1'b0, hs = 1'b1;
  logic [3:0]  adr = 4'h0;
  logic [7:0]  wd = 8'h00;
  logic [31:0] dat, rd;
  logic [13:0] pin = 14'h0000, pdir = 14'h0000, dier = 14'h0000;
  logic [5:0]  ton = 6'h00, toff = 6'h00, tm = 6'h00, trun;
  logic        ack, ls, sce, hse, lse, xte, pme, res, crst;
  int          fails = 0, compares = 0, n;
  always #4 clk = ~clk;
  low_speed_rc_osc_model u_low_speed_rc_osc (.clk_i(clk), .en_i(lse), .lsclk_o(ls));
  power_mode_wakeup_watchdog u_dut (.clk_i(clk), .rst_i(rst), .cyc_i(req), .stb_i(req), .we_i(we), .adr_i(adr),
    .sel_i(4'hF), .dat_i({24'h000000, wd}), .dat_o(dat), .ack_o(ack), .lsclk_i(ls), .hsrc_en_i(hs),
    .xtal_en_i(xt), .pin_i(pin), .pin_direction_ctrl_i(pdir), .pin_dier_i(dier), .timer_on_system_clock_i(ton),
    .timer_osc_off_i(toff), .timer_match_i(tm), .cmp_event_i(cmp), .system_clock_en_o(sce),
    .high_speed_rc_osc_en_o(hse), .low_speed_rc_osc_en_o(lse), .crystal_oscillator_en_o(xte),
    .program_memory_en_o(pme), .timer_run_o(trun), .resume_o(res), .chip_reset_o(crst));
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    @(posedge clk);
    while (ack !== 1'b1)
      @(posedge clk);
    rd = dat;
    req <= 1'b0;
  endtask : wb
  task automatic sleep(input logic [7:0] c, input logic [1:0] m);
    wb(1'b1, `ADDR_CTRL, c);
    wb(1'b0, `ADDR_CTRL, 8'h00);
    `CHK(rd[1:0], m)
  endtask : sleep
  task automatic wt(input int lim, input int lo, input int hi);
    for (n = 0; n < lim && res !== 1'b1; n++)
      @(negedge clk);
    `CHK(n >= lo && n <= hi, 1'b1)
  endtask : wt
  task automatic t_save;
    wb(1'b0, `ADDR_AUX, 8'h00);
    `CHK(rd[7:0], `AUX_RST)
    wb(1'b1, `ADDR_AUX, 8'h20);
    wb(1'b1, `ADDR_WAKE, 8'h40);
    ton <= 6'h03;
    toff <= 6'h04;
    dier <= 14'h0001;
    sleep(8'h02, 2'h1);
    `CHK({lse, hse, pme, trun}, 9'h1B8)
    tm <= 6'h01;
    cmp <= 1'b1;
    pin <= ~pin;
    repeat (40) @(posedge clk);
    wb(1'b0, `ADDR_CTRL, 8'h00);
    `CHK(rd[1:0], 2'h1)
    cmp <= 1'b0;
    tm <= 6'h08;
    wt(400, 170, 220);
    wb(1'b0, `ADDR_CTRL, 8'h00);
    `CHK(rd[1:0], 2'h0)
  endtask : t_save
  task automatic t_down;
    wb(1'b1, `ADDR_WAKE, 8'hC0);
    xt <= 1'b0;
    pdir <= 14'h0000;
    sleep(8'h04, 2'h2);
    `CHK({lse, hse, xte, sce, pme}, 5'h00)
    cmp <= 1'b1;
    repeat (40) @(posedge clk);
    wb(1'b0, `ADDR_CTRL, 8'h00);
    `CHK(rd[1:0], 2'h2)
    tm <= 6'h00;
    cmp <= 1'b0;
    pin <= ~pin;
    wt(400, 170, 220);
  endtask : t_down
  task automatic t_wdt;
    wb(1'b1, `ADDR_AUX, 8'h00);
    hs <= 1'b0;
    sleep(8'h02, 2'h1);
    `CHK({hse, xte, lse, sce}, 4'h2)
    cmp <= 1'b1;
    wt(13000, 11950, 12100);
    wb(1'b1, `ADDR_CTRL, 8'h01);
    wb(1'b0, `ADDR_STATUS, 8'h00);
    `CHK(rd < 32'h4, 1'b1)
    for (n = 0; n < 34000 && crst !== 1'b1; n++)
      @(negedge clk);
    `CHK(n > 32600 && n < 32800, 1'b1)
  endtask : t_wdt
  task automatic give_verdict;
    $display("fails %0d compares %0d", fails, compares);
    if (fails == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_save;
    t_down;
    t_wdt;
    give_verdict;
  end
  initial begin
    #600000;
    fails++;
    give_verdict;
  end
endmodule : power_mode_wakeup_watchdog_test
